// [common/cpp_regs.vh]
// Register map, field positions and timing constants of the card presence probe threshold logic.
// Assumes an 8-bit register port with 7-bit addresses; included by bare name.
`ifndef CPP_REGS_VH
`define CPP_REGS_VH

// Register offsets.
`define CPP_ADDR_OPTIONS      7'h3A
`define CPP_ADDR_Q_LOWER      7'h3F
`define CPP_ADDR_Q_UPPER      7'h40
`define CPP_ADDR_I_LOWER      7'h41
`define CPP_ADDR_I_RESULT     7'h42
`define CPP_ADDR_Q_RESULT     7'h43
`define CPP_ADDR_IRQ_STATUS   7'h06
`define CPP_ADDR_IRQ_MASK     7'h07

// Field positions.
`define CPP_OPT_FULL_DRIVE    3
`define CPP_OPT_FILTER        2
`define CPP_OPT_Q_CHANGING    1
`define CPP_OPT_I_CHANGING    0
`define CPP_QRES_SUPPRESS     6
`define CPP_IRQ_DETECT        0
`define CPP_IRQ_FILTER_FLAG   1

// Reset values.
`define CPP_RST_BYTE          8'h00
`define CPP_RST_SAMPLE        6'h00
`define CPP_RST_OPT           2'b00

// Timing: longest total sampling time in ps, clock period in ps.
`define CPP_SAMPLE_MAX_PS     4720000
`define CPP_CLK_PERIOD_PS     5000
`define CPP_SAMPLE_CYCLES     (`CPP_SAMPLE_MAX_PS / `CPP_CLK_PERIOD_PS)
`define CPP_CNT_W             10

`endif

// [hdl/cpp_noise_filter.v]
// Noise filter for one measurement channel of the card presence probe.
// Assumes samples arrive as single-cycle strobes between a start and an end pulse of one procedure.
`timescale 1ns/1ps
`include "cpp_regs.vh"

module cpp_noise_filter (
	// Clock and reset.
	input  wire       clk,
	input  wire       resetn,
	// Procedure framing.
	input  wire       start,
	input  wire       sample_valid,
	input  wire [5:0] sample,
	// Filtered value and instability flag.
	output reg  [5:0] filtered,
	output reg        changing
);

	reg        seen;
	reg  [5:0] last;
	wire [6:0] pair_sum;

	// Sum kept one bit wider so the mean of two full-scale samples cannot wrap.
	assign pair_sum = {1'b0, filtered} + {1'b0, sample};

	// Running mean of the filtered value and each new sample; a changed sample marks the channel as unstable.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			filtered <= `CPP_RST_SAMPLE;
			changing <= 1'b0;
			seen     <= 1'b0;
			last     <= `CPP_RST_SAMPLE;
		end else if (start) begin
			changing <= 1'b0;
			seen     <= 1'b0;
		end else if (sample_valid) begin
			last <= sample;
			seen <= 1'b1;
			if (!seen) begin
				filtered <= sample;
			end else begin
				filtered <= pair_sum[6:1];
				if (sample != last) begin
					changing <= 1'b1;
				end
			end
		end
	end

endmodule // cpp_noise_filter

// [hdl/cpp_irq_ctrl.v]
// Sticky interrupt status with mask and clear on read for the card presence probe.
// Assumes event pulses are one cycle wide and a read strobe of the status register clears it.
`timescale 1ns/1ps
`include "cpp_regs.vh"

module cpp_irq_ctrl (
	// Clock and reset.
	input  wire       clk,
	input  wire       resetn,
	// Events and software access.
	input  wire [7:0] events,
	input  wire       status_read,
	input  wire [7:0] mask,
	// State and interrupt line.
	output reg  [7:0] status,
	output wire       irq
);

	// A new event in the clearing cycle survives the read.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status <= `CPP_RST_BYTE;
		end else if (status_read) begin
			status <= events;
		end else begin
			status <= status | events;
		end
	end

	// Level output, high while any unmasked flag stands.
	assign irq = |(status & mask);

endmodule // cpp_irq_ctrl

// [hdl/cpp_threshold.v]
// Border comparison, result capture and interrupt gating of the card presence probe.
// Assumes the timing engine pulses start, sample strobes and end, and the register port follows one clock.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "cpp_regs.vh"

// Function
// - Raise detection interrupt when I measurement falls below the I lower border.
// - I upper border low bits sit in I lower border bits 7:6; exceed raises interrupt.
// - I result register holds last I value in bits 5:0, bits 7:6 read zero.
// - Q result register holds last Q value in bits 5:0, bit 7 reads zero.
// - Suppress bit 6 blocks detection interrupts until next procedure starts.
// - Filter bit 2 bases decision on filtered samples; sampling capped at 4.72us.
// - With filtering, options bit 1 flags a changing Q converter value.
// - With filtering, options bit 0 flags a changing I converter value.
// - Options bit 3 selects full transmitter drive or supply minus 0.4V.
// - Options register exists only on the later revision; else reserved.
// - I upper border assembled from top two bits of three border registers.
// - Detection request sets a dedicated flag in the interrupt status register.
// - Raise detection interrupt when Q measurement exceeds the Q upper border.
module cpp_threshold #(
	parameter LATE_REVISION = 1
) (
	// Clock and reset.
	input  wire       clk,
	input  wire       resetn,
	// Register port.
	input  wire [6:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata,
	// Detection timing engine.
	input  wire       probe_start,
	input  wire       probe_end,
	input  wire       sample_valid,
	input  wire [5:0] i_sample,
	input  wire [5:0] q_sample,
	// Front end control.
	output wire       full_drive_select,
	output wire       noise_filter_enable,
	output reg        sample_window_open,
	// Interrupt.
	output wire       irq
);

	// Border and option storage.
	reg  [7:0] q_lower_border;
	reg  [7:0] q_upper_border;
	reg  [7:0] i_lower_border;
	reg  [3:2] option_bits;
	reg  [5:0] i_channel_result;
	reg  [5:0] q_channel_result;
	reg        detect_irq_suppress;
	reg        q_value_changing;
	reg        i_value_changing;
	reg  [7:0] irq_mask;
	reg  [`CPP_CNT_W-1:0] window_count;

	// Filter outputs, interrupt vector and the unfiltered sample holders.
	wire [5:0] i_filtered;
	wire [5:0] q_filtered;
	wire       i_flt_changing;
	wire       q_flt_changing;
	wire [7:0] irq_status;
	reg  [7:0] irq_events;
	reg  [5:0] i_last;
	reg  [5:0] q_last;

	// Revision gate, assembled border, decision inputs and the port decodes.
	wire       options_present = (LATE_REVISION != 0);
	wire [5:0] i_upper_border;
	wire [5:0] i_decide;
	wire [5:0] q_decide;
	wire       detect_hit;
	wire       sel_status;
	wire       wr_q_lower;
	wire       wr_q_upper;
	wire       wr_i_lower;
	wire       wr_options;
	wire       wr_irq_mask;
	wire       wr_q_result;
	reg  [7:0] next_rdata;

	// Converts one raw address into a match, used by every write decode and the status read decode.
	function hit;
		input [6:0] addr;
		input [6:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// The six-bit upper border is spread over the top pairs of three registers, upper bits in
	// the lowest address, so software must write all three before the next procedure ends.
	assign i_upper_border = {q_lower_border[7:6], q_upper_border[7:6], i_lower_border[7:6]};

	// Decision source: filtered samples only when the option is present and enabled.
	// On the earlier revision the filter path is never selected, whatever was written.
	assign noise_filter_enable = options_present & option_bits[`CPP_OPT_FILTER];
	assign i_decide = noise_filter_enable ? i_filtered : i_last;
	assign q_decide = noise_filter_enable ? q_filtered : q_last;

	// Comparisons; the Q lower border takes no part in the decision in this design.
	// It is still stored and read back, so software may keep its own use of that field.
	assign detect_hit = (i_decide < i_lower_border[5:0])
		| (i_decide > i_upper_border)
		| (q_decide > q_upper_border[5:0]);

	// Reduced drive unless full drive is selected; the earlier revision always uses reduced drive.
	// Reduced drive saves current at the cost of detection range.
	assign full_drive_select = options_present & option_bits[`CPP_OPT_FULL_DRIVE];

	// Status read decode; reading the status register clears it.
	assign sel_status = hit(reg_addr, `CPP_ADDR_IRQ_STATUS);

	// Write decodes, one per writable location. The options decode is dropped on the earlier
	// revision, so that address behaves as a reserved location there and keeps no state.
	assign wr_q_lower  = reg_write & hit(reg_addr, `CPP_ADDR_Q_LOWER);
	assign wr_q_upper  = reg_write & hit(reg_addr, `CPP_ADDR_Q_UPPER);
	assign wr_i_lower  = reg_write & hit(reg_addr, `CPP_ADDR_I_LOWER);
	assign wr_options  = reg_write & hit(reg_addr, `CPP_ADDR_OPTIONS) & options_present;
	assign wr_irq_mask = reg_write & hit(reg_addr, `CPP_ADDR_IRQ_MASK);
	assign wr_q_result = reg_write & hit(reg_addr, `CPP_ADDR_Q_RESULT);

	// One filter per channel; both restart on a start pulse and see the same in-window strobes.
	cpp_noise_filter u_i_filter (
		.clk          (clk),
		.resetn       (resetn),
		.start        (probe_start),
		.sample_valid (sample_valid & sample_window_open),
		.sample       (i_sample),
		.filtered     (i_filtered),
		.changing     (i_flt_changing)
	);

	cpp_noise_filter u_q_filter (
		.clk          (clk),
		.resetn       (resetn),
		.start        (probe_start),
		.sample_valid (sample_valid & sample_window_open),
		.sample       (q_sample),
		.filtered     (q_filtered),
		.changing     (q_flt_changing)
	);

	// Event vector: detection request and, when filtering, an instability notice.
	// Both are single-cycle pulses taken at the procedure end only.
	always @* begin
		irq_events = 8'h00;
		irq_events[`CPP_IRQ_DETECT] = probe_end & detect_hit & ~detect_irq_suppress;
		irq_events[`CPP_IRQ_FILTER_FLAG] = probe_end & noise_filter_enable & (i_flt_changing | q_flt_changing);
	end

	// Status bit 0 is the detection flag, bit 1 the filter instability notice.
	cpp_irq_ctrl u_irq (
		.clk         (clk),
		.resetn      (resetn),
		.events      (irq_events),
		.status_read (reg_read & sel_status),
		.mask        (irq_mask),
		.status      (irq_status),
		.irq         (irq)
	);

	// Sampling window bounded so a long filtered measurement can never overrun the limit.
	// A procedure whose end never comes still gets its window closed, and later strobes are
	// ignored, so a stuck timing engine cannot stretch the sampling time.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_window_open <= 1'b0;
			window_count       <= {`CPP_CNT_W{1'b0}};
		end else if (probe_start) begin
			sample_window_open <= 1'b1;
			window_count       <= {`CPP_CNT_W{1'b0}};
		end else if (probe_end) begin
			sample_window_open <= 1'b0;
		end else if (sample_window_open) begin
			if (window_count == `CPP_SAMPLE_CYCLES - 1) begin
				sample_window_open <= 1'b0;
			end
			window_count <= window_count + 1'b1;
		end
	end

	// Unfiltered path keeps the latest in-window sample.
	// It runs whether or not the filter is on, so switching the filter off needs no warm-up.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			i_last <= `CPP_RST_SAMPLE;
			q_last <= `CPP_RST_SAMPLE;
		end else if (sample_valid & sample_window_open) begin
			i_last <= i_sample;
			q_last <= q_sample;
		end
	end

	// Results and instability flags change only at procedure end, together with the event.
	// Software reading the results after the interrupt thus sees the values that raised it.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			i_channel_result <= `CPP_RST_SAMPLE;
			q_channel_result <= `CPP_RST_SAMPLE;
			q_value_changing <= 1'b0;
			i_value_changing <= 1'b0;
		end else if (probe_end) begin
			i_channel_result <= i_decide;
			q_channel_result <= q_decide;
			q_value_changing <= noise_filter_enable & q_flt_changing;
			i_value_changing <= noise_filter_enable & i_flt_changing;
		end
	end

	// Q lower border. Its top pair carries the two upper bits of the I upper border, so a write here
	// moves both a Q border and an I border at once.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q_lower_border <= `CPP_RST_BYTE;
		end else if (wr_q_lower) begin
			q_lower_border <= reg_wdata;
		end
	end

	// Q upper border; its top pair carries the middle bits of the I upper border.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q_upper_border <= `CPP_RST_BYTE;
		end else if (wr_q_upper) begin
			q_upper_border <= reg_wdata;
		end
	end

	// I lower border; its top pair carries the two lowest bits of the I upper border.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			i_lower_border <= `CPP_RST_BYTE;
		end else if (wr_i_lower) begin
			i_lower_border <= reg_wdata;
		end
	end

	// Option bits. Only the drive level and the filter enable are stored here; the two instability
	// bits are read-only and kept with the results, so no write can fake them.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			option_bits <= `CPP_RST_OPT;
		end else if (wr_options) begin
			option_bits <= reg_wdata[`CPP_OPT_FULL_DRIVE:`CPP_OPT_FILTER];
		end
	end

	// Interrupt mask, laid out like the status register. Masking only hides the request on the
	// line; the status flag is still set, so polling software sees every detection.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_mask <= `CPP_RST_BYTE;
		end else if (wr_irq_mask) begin
			irq_mask <= reg_wdata;
		end
	end

	// Suppress bit. A start releases it even when software writes it in that same cycle, so a
	// late write can never block the procedure that has just begun.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			detect_irq_suppress <= 1'b0;
		end else if (probe_start) begin
			detect_irq_suppress <= 1'b0;
		end else if (wr_q_result) begin
			detect_irq_suppress <= reg_wdata[`CPP_QRES_SUPPRESS];
		end
	end

	// Read data source for the addressed location; unmapped and reserved locations give zero.
	always @* begin
		next_rdata = 8'h00;
		if (reg_read) begin
			case (reg_addr)
				`CPP_ADDR_OPTIONS: begin
					if (options_present) begin
						next_rdata = {4'h0, option_bits, q_value_changing, i_value_changing};
					end else begin
						next_rdata = 8'h00;
					end
				end
				`CPP_ADDR_Q_LOWER:    next_rdata = q_lower_border;
				`CPP_ADDR_Q_UPPER:    next_rdata = q_upper_border;
				`CPP_ADDR_I_LOWER:    next_rdata = i_lower_border;
				`CPP_ADDR_I_RESULT:   next_rdata = {2'b00, i_channel_result};
				`CPP_ADDR_Q_RESULT:   next_rdata = {1'b0, detect_irq_suppress, q_channel_result};
				`CPP_ADDR_IRQ_STATUS: next_rdata = irq_status;
				`CPP_ADDR_IRQ_MASK:   next_rdata = irq_mask;
				default:              next_rdata = 8'h00;
			endcase
		end
	end

	// Read data one cycle after the strobe and zero otherwise, so a stale byte never lingers
	// on the port between reads.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= `CPP_RST_BYTE;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // cpp_threshold

// [sim/cpp_threshold_props.sv]
// Checker of the threshold logic: register port, sample window and interrupt timing.
// Assumes it is bound to every instance of the top module and sees only its ports.
`timescale 1ns/1ps
module cpp_chk #(
	parameter LATE_REVISION = 1
) (
	// Clock and reset.
	input logic       clk,
	input logic       resetn,
	// Register port.
	input logic [6:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_write,
	input logic       reg_read,
	input logic [7:0] reg_rdata,
	// Procedure link and front end.
	input logic       probe_start,
	input logic       probe_end,
	input logic       sample_valid,
	input logic [5:0] i_sample,
	input logic [5:0] q_sample,
	input logic       full_drive_select,
	input logic       noise_filter_enable,
	input logic       sample_window_open,
	input logic       irq
);
	// One clock domain, so one clocking and one reset guard serve every property.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Read data may only stand in the cycle after a read.
	property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
	property p_ires_top; $past(reg_read && reg_addr == 7'h42) |-> reg_rdata[7:6] == 2'b00; endproperty
	a_ires_top: assert property (p_ires_top) else $error("I result reserved bits set");
	property p_qres_top; $past(reg_read && reg_addr == 7'h43) |-> !reg_rdata[7]; endproperty
	a_qres_top: assert property (p_qres_top) else $error("Q result reserved bit set");
	// Drive and filter outputs follow the options byte, gated by the revision.
	property p_drive; reg_write && reg_addr == 7'h3A |=> full_drive_select == (LATE_REVISION != 0 && $past(reg_wdata[3]));
	endproperty
	a_drive: assert property (p_drive) else $error("drive level select wrong");
	property p_filt; reg_write && reg_addr == 7'h3A |=> noise_filter_enable == (LATE_REVISION != 0 && $past(reg_wdata[2]));
	endproperty
	a_filt: assert property (p_filt) else $error("filter enable wrong");
	// The sampling window opens after a start and never outlives the longest sampling time.
	property p_win_open; probe_start |=> sample_window_open; endproperty
	a_win_open: assert property (p_win_open) else $error("window did not open");
	property p_win_cap; $rose(sample_window_open) |-> ##[1:945] !sample_window_open; endproperty
	a_win_cap: assert property (p_win_cap) else $error("window open too long");
	// The interrupt moves only after a procedure end or a register access.
	property p_irq_quiet; !$past(probe_end) && !$past(reg_write) && !$past(reg_read) |-> $stable(irq); endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt moved without cause");
	property p_stat_clr; reg_read && reg_addr == 7'h06 && !probe_end |=> !irq; endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("status read left interrupt up");
	c_hit: cover property (probe_end ##1 irq);
	c_clr: cover property (reg_read && reg_addr == 7'h06 && irq);
	c_win: cover property ($fell(sample_window_open));
endmodule // cpp_chk

bind cpp_threshold cpp_chk #(.LATE_REVISION(LATE_REVISION)) u_chk (.clk(clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .probe_start(probe_start), .probe_end(probe_end), .sample_valid(sample_valid),
	.i_sample(i_sample), .q_sample(q_sample), .full_drive_select(full_drive_select),
	.noise_filter_enable(noise_filter_enable), .sample_window_open(sample_window_open), .irq(irq));

// [sim/tb.sv]
// Testbench of the threshold logic: register and detection procedure sequences.
// Assumes the bench alone drives both instances; the second stands for the early revision.
`timescale 1ns/1ps
module tb;
	// Bench drive and design outputs.
	reg         clk = 0, resetn = 0, reg_write = 0, reg_read = 0;
	reg         probe_start = 0, probe_end = 0, sample_valid = 0;
	reg  [6:0]  reg_addr = 7'h00;
	reg  [7:0]  reg_wdata = 8'h00, od;
	reg  [5:0]  i_sample = 6'h00, q_sample = 6'h00;
	reg  [12:0] e;
	wire [7:0]  reg_rdata, old_rdata;
	wire        full_drive_select, noise_filter_enable, sample_window_open, irq, old_full, old_filt;
	integer     err_count = 0, samples_checked = 0, k;
	// Registers with reset value zero, and {I, Q, hit} cases on and beside each border.
	localparam [55:0] REGS = {7'h3A, 7'h3F, 7'h40, 7'h41, 7'h42, 7'h43, 7'h06, 7'h07};
	localparam [90:0] TBL = {6'h14, 6'h05, 1'b0, 6'h09, 6'h05, 1'b1, 6'h0A, 6'h05, 1'b0, 6'h28, 6'h05, 1'b0,
		6'h29, 6'h05, 1'b1, 6'h14, 6'h14, 1'b0, 6'h14, 6'h15, 1'b1};

	// Later revision under test.
	cpp_threshold DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .probe_start(probe_start),
		.probe_end(probe_end), .sample_valid(sample_valid), .i_sample(i_sample), .q_sample(q_sample),
		.full_drive_select(full_drive_select), .noise_filter_enable(noise_filter_enable),
		.sample_window_open(sample_window_open), .irq(irq));
	// Early revision, fed the same traffic; only its options behaviour is judged.
	cpp_threshold #(.LATE_REVISION(0)) DUT_early (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(old_rdata),
		.probe_start(probe_start), .probe_end(probe_end), .sample_valid(sample_valid), .i_sample(i_sample),
		.q_sample(q_sample), .full_drive_select(old_full), .noise_filter_enable(old_filt),
		.sample_window_open(), .irq());

	// 200 MHz clock.
	always #2.5 clk = ~clk;

	// Byte compare; every result is widened to a byte.
	task chk(input [7:0] got, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask

	// One-cycle write strobe.
	task wr(input [6:0] a, input [7:0] dt);
		begin
			@(posedge clk);
			reg_write <= 1'b1;
			reg_addr <= a;
			reg_wdata <= dt;
			@(posedge clk);
			reg_write <= 1'b0;
			#1;
		end
	endtask

	// One-cycle read strobe; data are taken in the following cycle only.
	task rd(input [6:0] a, input [7:0] exp);
		begin
			@(posedge clk);
			reg_read <= 1'b1;
			reg_addr <= a;
			@(posedge clk);
			reg_read <= 1'b0;
			#1;
			od = old_rdata;
			chk(reg_rdata, exp);
		end
	endtask

	// One procedure with two sample pairs; sup sets the suppress bit after the start.
	task probe(input [5:0] i1, input [5:0] q1, input [5:0] i2, input [5:0] q2, input sup);
		begin
			@(posedge clk);
			probe_start <= 1'b1;
			@(posedge clk);
			probe_start <= 1'b0;
			if (sup)
				wr(7'h43, 8'h40);
			@(posedge clk);
			sample_valid <= 1'b1;
			i_sample <= i1;
			q_sample <= q1;
			@(posedge clk);
			i_sample <= i2;
			q_sample <= q2;
			@(posedge clk);
			sample_valid <= 1'b0;
			probe_end <= 1'b1;
			@(posedge clk);
			probe_end <= 1'b0;
			#1;
		end
	endtask

	// Counts, verdict and end of run.
	task print_verdict;
		begin
			$display("mismatches=%0d comparisons=%0d", err_count, samples_checked);
			if (err_count == 0 && samples_checked > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// Hang guard: the whole sequence needs far fewer cycles than this.
	initial begin
		#100000;
		err_count = err_count + 1;
		print_verdict;
	end

	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		for (k = 0; k < 8; k = k + 1)
			rd(REGS[k*7 +: 7], 8'h00);
		rd(7'h10, 8'h00);
		// Borders: I lower 10, I upper 40 spread over three bytes, Q upper 20.
		wr(7'h3F, 8'h80);
		wr(7'h40, 8'h94);
		wr(7'h41, 8'h0A);
		wr(7'h07, 8'h01);
		rd(7'h3F, 8'h80);
		rd(7'h40, 8'h94);
		rd(7'h41, 8'h0A);
		for (k = 0; k < 7; k = k + 1) begin
			e = TBL[k*13 +: 13];
			probe(e[12:7], e[6:1], e[12:7], e[6:1], 1'b0);
			chk({7'h00, irq}, {7'h00, e[0]});
			rd(7'h42, {2'b00, e[12:7]});
			rd(7'h43, {2'b00, e[6:1]});
			rd(7'h06, {7'h00, e[0]});
			chk({7'h00, irq}, 8'h00);
		end
		// A masked hit still marks the status register.
		wr(7'h07, 8'h00);
		probe(6'h29, 6'h05, 6'h29, 6'h05, 1'b0);
		chk({7'h00, irq}, 8'h00);
		rd(7'h06, 8'h01);
		wr(7'h07, 8'h01);
		// Suppress holds off a hit, and the next start lifts it.
		probe(6'h29, 6'h05, 6'h29, 6'h05, 1'b1);
		chk({7'h00, irq}, 8'h00);
		rd(7'h43, 8'h45);
		rd(7'h06, 8'h00);
		probe(6'h29, 6'h05, 6'h29, 6'h05, 1'b0);
		chk({7'h00, irq}, 8'h01);
		rd(7'h06, 8'h01);
		// Options: writable bits only, and nothing on the early revision.
		wr(7'h3A, 8'hFF);
		rd(7'h3A, 8'h0C);
		chk(od, 8'h00);
		chk({6'h00, full_drive_select, noise_filter_enable}, 8'h03);
		chk({6'h00, old_full, old_filt}, 8'h00);
		// Filtered decisions: a changing I value, then a changing Q value.
		probe(6'h14, 6'h05, 6'h16, 6'h05, 1'b0);
		rd(7'h3A, 8'h0D);
		rd(7'h42, 8'h15);
		rd(7'h06, 8'h02);
		probe(6'h14, 6'h05, 6'h14, 6'h07, 1'b0);
		rd(7'h3A, 8'h0E);
		rd(7'h43, 8'h06);
		rd(7'h06, 8'h02);
		wr(7'h3A, 8'h00);
		chk({6'h00, full_drive_select, noise_filter_enable}, 8'h00);
		// A procedure whose end is late: the window stands 944 cycles, then late samples are ignored.
		@(posedge clk);
		probe_start <= 1'b1;
		@(posedge clk);
		probe_start <= 1'b0;
		repeat (943) @(posedge clk);
		#1;
		chk({7'h00, sample_window_open}, 8'h01);
		@(posedge clk);
		#1;
		chk({7'h00, sample_window_open}, 8'h00);
		@(posedge clk);
		sample_valid <= 1'b1;
		i_sample <= 6'h29;
		@(posedge clk);
		sample_valid <= 1'b0;
		probe_end <= 1'b1;
		@(posedge clk);
		probe_end <= 1'b0;
		rd(7'h42, 8'h14);
		rd(7'h06, 8'h00);
		print_verdict;
	end
endmodule // tb
